// [secreg_cmd.sv]
// Purpose: Security page, unique ID and software reset command handling
// Assumes: SPI host drives i_cs_n, i_sck and i_mosi; sck is quiet outside frames
// Notes:   Frame logic runs on i_sck, execution on i_clk
//
// Functional notes
// R1: Low write-protect pin blocks lock-bit changes
// R2: Reset only on 66h then 99h
// R3: Any other command disarms pending reset
// R4: Reset aborts operation, clears volatile state
// R5: About 30 us reset, commands ignored
// R6: Host checks busy and suspend flags first
// R7: 4Bh, four dummy bytes, 64-bit ID out
// R8: Page erase needs write enable latch set
// R9: 44h plus address, erase at chip-select rise
// R10: Erase ignores lowest eight address bits
// R11: Erase aborts unless exactly 24 address bits
// R12: Busy while erasing, cleared when done
// R13: Host polls status instead of waiting
// R14: Aborted erase clears write enable latch
// R15: Page lock bits are one-way
// R16: Erase of locked page ignored
// R17: Page chosen by address fields 1h-3h
// R18: Program goes through the 256-byte buffer
// R19: 42h plus address gives first byte
// R20: Low address byte selects starting byte
// R21: 48h, address, dummy, then sequential bytes
// R22: Read wraps 3FFh to 0; CS ends
// R23: 06h at byte boundary sets latch
// R24: Lock bits at status-two bits 5..3
// R25: Busy at status-one bit 0
// R26: Program data buffered, executed, latch cleared
// R27: Program refused on locked page
`timescale 1ns/1ns
module secreg_cmd #(
    parameter int PP_CYCLES = secreg_pkg::PAGE_PROGRAM_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_sck,
    input  wire logic       i_cs_n,
    input  wire logic       i_mosi,
    output logic            o_miso,
    output logic            o_miso_oe,
    input  wire logic       i_wp_n,
    input  wire logic       i_lock_set_req,
    input  wire logic [2:0] i_lock_set_bits,
    input  wire logic       i_array_busy,
    input  wire logic       i_erase_suspended_flag,
    input  wire logic       i_program_suspended_flag,
    output logic            o_busy_flag,
    output logic            o_write_enable_latch,
    output logic [2:0]      o_page_lock_bits,
    output logic [7:0]      o_status1,
    output logic [7:0]      o_status2,
    output logic            o_lock_write_allowed,
    output logic            o_sw_reset
);
    import secreg_pkg::*;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                  cs_m;
        logic                  cs_s;
        logic                  cs_p;
        logic                  wp_m;
        logic                  wp_s;
        state_t                state;
        logic [TIMER_W-1:0]    timer;
        logic [1:0]            page;
        logic                  write_enable_latch;
        logic                  armed;
        logic                  busy;
        logic [2:0]            lock;
        logic                  sw_rst;
        logic [7:0]            stat1;
        logic [7:0]            stat2;
    } ctrl_t;
    typedef struct packed {
        logic                  busy_m;
        logic                  busy_s;
        logic [NBITS_W-1:0]    nbits;
        logic [6:0]            rx_sh;
        logic [7:0]            opcode;
        logic [23:0]           addr;
        mode_t                 mode;
        logic [READ_IDX_W-1:0] rd_idx;
        logic [7:0]            wr_ptr;
        logic [63:0]           tx_sh;
        logic [255:0]          mask;
    } link_t;
    typedef struct packed {
        logic                  in_frame;
    } frame_t;
    typedef struct packed {
        logic                  so;
        logic                  oe;
    } out_t;

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic logic [1:0] page_sel(input logic [23:0] a);
        return (a[23:16] == SEC_ADDR_HIGH && a[11:8] == SEC_ADDR_MID &&
                a[15:12] >= SEC_PAGE_FIRST && a[15:12] <= SEC_PAGE_LAST) ? a[13:12] : 2'h0; // R17
    endfunction
    function automatic logic page_locked(input logic [2:0] lk, input logic [1:0] p);
        return (p == 2'h0) ? 1'b1 : lk[p - 2'h1];
    endfunction
    ctrl_t  ct_q, ct_d;
    link_t  lk_q, lk_d;
    frame_t fr_q, fr_d;
    out_t   ou_q, ou_d;
    logic [7:0] secmem [MEM_LO:MEM_HI];
    logic [7:0] pbuf   [0:255];
    logic                  frame_rst;
    logic                  buf_we;
    logic [7:0]            byte_now;
    logic                  mem_we;
    logic [READ_IDX_W-1:0] mem_addr;
    logic [7:0]            mem_wdata;
    assign frame_rst = i_rst | i_cs_n;

    // ------------------------------------------------------------------
    // Link side: bit and byte capture on rising sck
    // ------------------------------------------------------------------
    always_comb begin
        logic [NBITS_W-1:0]    nb;
        logic                  bdone;
        logic [23:0]           a_new;
        logic [READ_IDX_W-1:0] ri;
        lk_d     = lk_q;
        fr_d     = fr_q;
        buf_we   = 1'b0;
        byte_now = {lk_q.rx_sh, i_mosi};
        nb       = BITS_SATURATE;
        a_new    = {lk_q.addr[15:0], byte_now};
        ri       = lk_q.rd_idx;
        fr_d.in_frame = 1'b1;
        lk_d.busy_m   = ct_q.busy;
        lk_d.busy_s   = lk_q.busy_m;
        if (!fr_q.in_frame) begin
            nb          = 16'h0001;
            lk_d.mask   = '0;
            lk_d.mode   = M_NONE;
            lk_d.opcode = 8'h00;
            lk_d.addr   = 24'h000000;
        end else if (lk_q.nbits != BITS_SATURATE) begin
            nb = lk_q.nbits + 16'h0001;
        end
        lk_d.nbits = nb;
        lk_d.rx_sh = byte_now[6:0];
        lk_d.tx_sh = {lk_q.tx_sh[62:0], 1'b0};
        bdone      = (nb[2:0] == 3'h0);
        if (bdone) begin
            if (nb == BITS_OPCODE) begin
                lk_d.opcode = byte_now;
                if (!lk_q.busy_s) begin
                    case (byte_now)
                        OP_SEC_READ:    lk_d.mode = M_READ; // R21
                        OP_READ_UID:    lk_d.mode = M_UID; // R7
                        OP_SEC_PROGRAM: lk_d.mode = M_PROG; // R19
                        default:        lk_d.mode = M_NONE;
                    endcase
                end
            end else if (nb == BITS_ADDR_1 || nb == BITS_ADDR_2) begin
                lk_d.addr = a_new;
            end else if (nb == BITS_ADDR_END) begin
                lk_d.addr   = a_new;
                lk_d.rd_idx = {a_new[13:12], a_new[7:0]}; // R20
                lk_d.wr_ptr = a_new[7:0]; // R20
            end
            if (nb >= BITS_DATA_START) begin
                case (lk_q.mode)
                    M_READ: begin
                        lk_d.tx_sh  = {(ri[9:8] == 2'h0) ? ERASED_BYTE : secmem[ri], 56'h0};
                        lk_d.rd_idx = ri + 10'h001; // R22
                    end
                    M_UID: begin
                        if (nb == BITS_DATA_START) begin
                            lk_d.tx_sh = UNIQUE_ID; // R7
                        end
                    end
                    M_PROG: begin
                        buf_we                 = 1'b1; // R18
                        lk_d.mask[lk_q.wr_ptr] = 1'b1; // R26
                        lk_d.wr_ptr            = lk_q.wr_ptr + 8'h01;
                    end
                    default: ;
                endcase
            end
        end
    end
    always_ff @(posedge i_sck or posedge frame_rst) begin
        if (frame_rst) begin
            fr_q <= '0;
        end else begin
            fr_q <= fr_d;
        end
    end
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            lk_q <= '0;
        end else begin
            lk_q <= lk_d;
        end
    end
    always_ff @(posedge i_sck) begin
        if (buf_we) begin
            pbuf[lk_q.wr_ptr] <= byte_now;
        end
    end
    // ------------------------------------------------------------------
    // Link side: serial output on falling sck
    // ------------------------------------------------------------------
    always_comb begin
        ou_d    = ou_q;
        ou_d.so = lk_q.tx_sh[63];
        ou_d.oe = fr_q.in_frame && lk_q.nbits >= BITS_DATA_START &&
                  (lk_q.mode == M_READ || lk_q.mode == M_UID); // R22
    end
    always_ff @(negedge i_sck or posedge frame_rst) begin
        if (frame_rst) begin
            ou_q <= '0;
        end else begin
            ou_q <= ou_d;
        end
    end
    assign o_miso    = ou_q.so;
    assign o_miso_oe = ou_q.oe;
    // ------------------------------------------------------------------
    // System side: command execution
    // ------------------------------------------------------------------
    always_comb begin
        logic                  fend;
        logic                  whole;
        logic [1:0]            pg;
        logic [READ_IDX_W-1:0] ma;
        ct_d      = ct_q;
        mem_we    = 1'b0;
        ma        = {ct_q.page, ct_q.timer[7:0]};
        mem_addr  = ma;
        mem_wdata = ERASED_BYTE;
        ct_d.cs_m = i_cs_n;
        ct_d.cs_s = ct_q.cs_m;
        ct_d.cs_p = ct_q.cs_s;
        ct_d.wp_m = i_wp_n;
        ct_d.wp_s = ct_q.wp_m;
        ct_d.sw_rst = 1'b0;
        fend  = ct_q.cs_s && !ct_q.cs_p && lk_q.nbits >= BITS_OPCODE;
        whole = (lk_q.nbits[2:0] == 3'h0);
        pg    = page_sel(lk_q.addr);
        if (i_lock_set_req && ct_q.wp_s) begin
            ct_d.lock = ct_q.lock | i_lock_set_bits; // R1 R15
        end
        if (ct_q.state != S_IDLE) begin
            ct_d.timer = ct_q.timer + 20'h00001;
        end
        case (ct_q.state)
            S_ERASE, S_PROG: begin
                if (ct_q.timer[TIMER_W-1:8] == '0 && ma >= MEM_LO[READ_IDX_W-1:0]) begin
                    if (ct_q.state == S_ERASE) begin
                        mem_we = 1'b1; // R9
                    end else if (lk_q.mask[ct_q.timer[7:0]]) begin
                        mem_we    = 1'b1; // R26
                        mem_wdata = secmem[ma] & pbuf[ct_q.timer[7:0]];
                    end
                end
                if (ct_q.timer == TIMER_W'(PP_CYCLES - 1)) begin
                    ct_d.state = S_IDLE; // R12
                    ct_d.write_enable_latch   = 1'b0; // R26
                end
            end
            S_RESET: begin
                if (ct_q.timer == TIMER_W'(RESET_CYCLES - 1)) begin
                    ct_d.state = S_IDLE; // R5
                end
            end
            default: ;
        endcase
        if (fend && ct_q.state != S_RESET) begin // R5
            ct_d.armed = whole && lk_q.opcode == OP_ENABLE_RESET; // R2 R3
            if (whole && lk_q.opcode == OP_RESET_DEVICE && ct_q.armed) begin
                ct_d.sw_rst = 1'b1; // R4
                ct_d.state  = S_RESET;
                ct_d.timer  = '0;
                ct_d.write_enable_latch    = 1'b0;
                mem_we      = 1'b0;
            end else if (ct_q.state == S_IDLE) begin
                case (lk_q.opcode)
                    OP_WRITE_ENABLE:  ct_d.write_enable_latch = whole || ct_d.write_enable_latch; // R23
                    OP_WRITE_DISABLE: ct_d.write_enable_latch = whole ? 1'b0 : ct_d.write_enable_latch;
                    OP_SEC_ERASE: begin
                        if (ct_q.write_enable_latch) begin // R8
                            if (lk_q.nbits == BITS_ADDR_END && !page_locked(ct_q.lock, pg) &&
                                !i_array_busy) begin // R10 R11 R16
                                ct_d.state = S_ERASE;
                                ct_d.page  = pg;
                                ct_d.timer = '0;
                            end else begin
                                ct_d.write_enable_latch = 1'b0; // R14
                            end
                        end
                    end
                    OP_SEC_PROGRAM: begin
                        if (ct_q.write_enable_latch) begin
                            if (whole && lk_q.nbits >= BITS_DATA_START &&
                                !page_locked(ct_q.lock, pg) && !i_array_busy) begin // R27
                                ct_d.state = S_PROG;
                                ct_d.page  = pg;
                                ct_d.timer = '0;
                            end else begin
                                ct_d.write_enable_latch = 1'b0;
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end
        ct_d.busy  = (ct_d.state != S_IDLE);
        ct_d.stat1 = 8'h00;
        ct_d.stat1[STAT1_BUSY_BIT] = ct_d.busy | i_array_busy; // R25
        ct_d.stat1[STAT1_WEL_BIT]  = ct_d.write_enable_latch;
        ct_d.stat2 = 8'h00;
        ct_d.stat2[STAT2_LOCK_LSB +: 3] = ct_d.lock; // R24
        ct_d.stat2[STAT2_ESUS_BIT] = i_erase_suspended_flag & !ct_d.sw_rst;
        ct_d.stat2[STAT2_PSUS_BIT] = i_program_suspended_flag & !ct_d.sw_rst;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ct_q <= '0;
        end else begin
            ct_q <= ct_d;
        end
    end
    always_ff @(posedge i_clk) begin
        if (mem_we) begin
            secmem[mem_addr] <= mem_wdata;
        end
    end
    assign o_busy_flag          = ct_q.busy;
    assign o_write_enable_latch = ct_q.write_enable_latch;
    assign o_page_lock_bits     = ct_q.lock;
    assign o_status1            = ct_q.stat1;
    assign o_status2            = ct_q.stat2;
    assign o_lock_write_allowed = ct_q.wp_s;
    assign o_sw_reset           = ct_q.sw_rst;
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_lock_sticky: assert property (@(posedge i_clk) disable iff (i_rst) // R15
        (ct_q.lock & ~ct_d.lock) == 3'h0)
        else $error("page lock bit cleared");

    a_wp_blocks_lock: assert property (@(posedge i_clk) disable iff (i_rst) // R1
        (!ct_q.wp_s && i_lock_set_req) |=> $stable(o_page_lock_bits))
        else $error("lock bits changed while write-protected");

    a_reset_busy_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R5
        o_sw_reset |-> o_busy_flag [*8])
        else $error("busy not held after reset");

    a_reset_clears_wel: assert property (@(posedge i_clk) disable iff (i_rst) // R4
        o_sw_reset |-> !o_write_enable_latch && !o_status2[STAT2_ESUS_BIT])
        else $error("volatile state kept over reset");

    a_disarm_other: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        (ct_q.cs_s && !ct_q.cs_p && lk_q.nbits >= BITS_OPCODE && ct_q.state != S_RESET &&
         lk_q.opcode != OP_ENABLE_RESET) |=> !ct_q.armed)
        else $error("reset stayed armed");

    a_erase_starts_busy: assert property (@(posedge i_clk) disable iff (i_rst) // R12
        (ct_q.state == S_IDLE && ct_d.state == S_ERASE) |=> o_busy_flag ##0 o_status1[STAT1_BUSY_BIT])
        else $error("erase not reported busy");

    a_locked_no_erase: assert property (@(posedge i_clk) disable iff (i_rst) // R16
        (ct_d.state == S_ERASE && ct_q.state == S_IDLE) |-> !page_locked(ct_q.lock, ct_d.page))
        else $error("erase started on locked page");

    a_done_clears_wel: assert property (@(posedge i_clk) disable iff (i_rst) // R26
        $fell(o_busy_flag) |-> !o_write_enable_latch)
        else $error("latch set after operation end");

    a_short_erase_wel: assert property (@(posedge i_clk) disable iff (i_rst) // R14
        (ct_q.cs_s && !ct_q.cs_p && ct_q.state == S_IDLE && lk_q.opcode == OP_SEC_ERASE &&
         lk_q.nbits != BITS_ADDR_END && lk_q.nbits >= BITS_OPCODE) |=> !o_write_enable_latch && !o_busy_flag)
        else $error("bad erase frame kept latch");
endmodule

// [secreg_pkg.sv]
// Purpose: Shared constants and types for the security page command block
// Assumes: 50 MHz system clock, SPI mode 0 or 3 on the link clock
// Notes:   Timing figures are kept in their own units and converted here
package secreg_pkg;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_ENABLE_RESET  = 8'h66;
    localparam logic [7:0] OP_RESET_DEVICE  = 8'h99;
    localparam logic [7:0] OP_READ_UID      = 8'h4B;
    localparam logic [7:0] OP_SEC_ERASE     = 8'h44;
    localparam logic [7:0] OP_SEC_PROGRAM   = 8'h42;
    localparam logic [7:0] OP_SEC_READ      = 8'h48;

    // ------------------------------------------------------------------
    // Frame bit counts
    // ------------------------------------------------------------------
    localparam int          NBITS_W         = 16;
    localparam logic [15:0] BITS_OPCODE     = 16'h0008;
    localparam logic [15:0] BITS_ADDR_1     = 16'h0010;
    localparam logic [15:0] BITS_ADDR_2     = 16'h0018;
    localparam logic [15:0] BITS_ADDR_END   = 16'h0020;
    localparam logic [15:0] BITS_DATA_START = 16'h0028;
    localparam logic [15:0] BITS_SATURATE   = 16'hFFFF;

    // ------------------------------------------------------------------
    // Address map of the security pages
    // ------------------------------------------------------------------
    localparam logic [7:0] SEC_ADDR_HIGH    = 8'h00;
    localparam logic [3:0] SEC_ADDR_MID     = 4'h0;
    localparam logic [3:0] SEC_PAGE_FIRST   = 4'h1;
    localparam logic [3:0] SEC_PAGE_LAST    = 4'h3;
    localparam int         READ_IDX_W       = 10;
    localparam int         MEM_LO           = 256;
    localparam int         MEM_HI           = 1023;
    localparam logic [7:0] ERASED_BYTE      = 8'hFF;
    localparam logic [7:0] PAGE_LAST_BYTE   = 8'hFF;

    // ------------------------------------------------------------------
    // Status byte fields
    // ------------------------------------------------------------------
    localparam int STAT1_BUSY_BIT = 0;
    localparam int STAT1_WEL_BIT  = 1;
    localparam int STAT2_PSUS_BIT = 2;
    localparam int STAT2_LOCK_LSB = 3;
    localparam int STAT2_ESUS_BIT = 7;

    // Arbitrary value, stands in for the factory identifier
    localparam logic [63:0] UNIQUE_ID = 64'h5A5A_1234_C3C3_0F0F;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_MHZ          = 50;
    localparam int RESET_TIME_NS         = 30000;
    localparam int RESET_CYCLES          = (RESET_TIME_NS * CLK_FREQ_MHZ) / 1000;
    localparam int PAGE_PROGRAM_TIME_US  = 1000;
    localparam int PAGE_PROGRAM_CYCLES   = PAGE_PROGRAM_TIME_US * CLK_FREQ_MHZ;
    localparam int TIMER_W               = 20;

    typedef enum logic [1:0] {S_IDLE, S_RESET, S_ERASE, S_PROG} state_t;
    typedef enum logic [1:0] {M_NONE, M_READ, M_UID, M_PROG} mode_t;

endpackage

// [secreg_host.sv]
// Purpose: SPI host model driving the security page block
// Assumes: mode 0, link clock period 80 ns
// Notes:   Clock stands still outside frames
`timescale 1ns/1ns
module secreg_host (
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_mosi,
    input  wire logic i_miso
);
    logic [63:0] rx;
    initial begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
        rx     = '0;
    end
    // Sends ntx bits MSB first, then clocks nrx bits back into rx
    task automatic frame(input logic [7:0] tx[$], input int ntx, input int nrx);
        #13 o_cs_n = 1'b0;
        for (int i = 0; i < ntx + nrx; i++) begin
            o_mosi = (i < ntx) ? tx[i / 8][7 - i % 8] : ~o_mosi;
            #40 o_sck = 1'b1;
            rx = {rx[62:0], i_miso};
            #40 o_sck = 1'b0;
        end
        #40 o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #300;
    endtask
endmodule

// [spi_flash_secreg_reset_cmds_tb_top.sv]
// Purpose: Self-checking bench for the security page block
// Assumes: 50 MHz system clock, short page program count
// Notes:   Every scenario judges its own results
`timescale 1ns/1ns
module spi_flash_secreg_reset_cmds_tb_top;
    import secreg_pkg::*;
    logic       clk = 0, rst = 0, wp_n = 1, lreq = 0, ab = 0, esus = 0, psus = 0;
    logic       sck, cs_n, mosi, miso, oe, busy, write_enable_latch, lwa, swr;
    logic [2:0] lbits = 0, locks;
    logic [7:0] s1, s2;
    int         errors = 0, compares = 0, resets = 0;
    always #10 clk = ~clk;
    always @(posedge clk) if (swr === 1'b1) resets++;
    secreg_host host (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(oe ? miso : 1'b1));
    secreg_cmd #(.PP_CYCLES(300)) dut (
        .i_clk(clk), .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso),
        .o_miso_oe(oe), .i_wp_n(wp_n), .i_lock_set_req(lreq), .i_lock_set_bits(lbits),
        .i_array_busy(ab), .i_erase_suspended_flag(esus), .i_program_suspended_flag(psus),
        .o_busy_flag(busy), .o_write_enable_latch(write_enable_latch), .o_page_lock_bits(locks), .o_status1(s1),
        .o_status2(s2), .o_lock_write_allowed(lwa), .o_sw_reset(swr));
    task check(string name, logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task finish_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n == 2000) begin
            errors++;
            finish_test;
        end
    endtask
    task we;
        host.frame('{8'h06}, 8, 0);
    endtask
    task pulse;
        @(posedge clk);
        lreq <= 1'b1;
        @(posedge clk);
        lreq <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task t_we;
        host.frame('{8'h04}, 8, 0);
        host.frame('{8'h06, 8'h00}, 12, 0);
        check("wel", write_enable_latch, 0);
        we();
        check("wel", write_enable_latch, 1);
        check("status1", s1, 8'h02);
        $display("test we done");
    endtask
    task t_erase_prog;
        for (int p = 1; p <= 3; p++) begin
            we();
            host.frame('{8'h44, 8'h00, 8'(p << 4), 8'h77}, 32, 0);
            check("busy", s1[0], 1);
            wait_idle();
            check("wel", write_enable_latch, 0);
        end
        we();
        host.frame('{8'h42, 8'h00, 8'h10, 8'h05, 8'hA5, 8'h3C}, 48, 0);
        wait_idle();
        we();
        host.frame('{8'h42, 8'h00, 8'h30, 8'hFF, 8'h12}, 40, 0);
        wait_idle();
        check("wel", write_enable_latch, 0);
        host.frame('{8'h48, 8'h00, 8'h10, 8'h04, 8'h00}, 40, 24);
        check("read", host.rx[23:0], 24'hFFA53C);
        host.frame('{8'h48, 8'h00, 8'h33, 8'hFF, 8'h00}, 40, 16);
        check("wrap", host.rx[15:0], 16'h12FF);
        check("oe", oe, 0);
        host.frame('{8'h4B, 8'h00, 8'h00, 8'h00, 8'h00}, 40, 64);
        check("uid", host.rx, UNIQUE_ID);
        $display("test erase program done");
    endtask
    task t_abort;
        host.frame('{8'h44, 8'h00, 8'h10, 8'h00}, 32, 0);
        check("busy", busy, 0);
        we();
        host.frame('{8'h44, 8'h00, 8'h10, 8'h00}, 31, 0);
        check("busy", busy, 0);
        check("wel", write_enable_latch, 0);
        we();
        host.frame('{8'h44, 8'h00, 8'h10}, 24, 0);
        check("wel", write_enable_latch, 0);
        $display("test abort done");
    endtask
    task t_lock;
        wp_n  <= 1'b0;
        lbits <= 3'h1;
        repeat (4) @(posedge clk);
        pulse();
        check("locks", locks, 0);
        check("allowed", lwa, 0);
        wp_n <= 1'b1;
        repeat (4) @(posedge clk);
        pulse();
        lbits <= 3'h0;
        pulse();
        check("locks", locks, 1);
        check("status2", s2, 8'h08);
        we();
        host.frame('{8'h44, 8'h00, 8'h10, 8'h00}, 32, 0);
        check("busy", busy, 0);
        we();
        host.frame('{8'h42, 8'h00, 8'h10, 8'h05, 8'h00}, 40, 0);
        check("wel", write_enable_latch, 0);
        host.frame('{8'h48, 8'h00, 8'h10, 8'h05, 8'h00}, 40, 8);
        check("kept", host.rx[7:0], 8'hA5);
        esus <= 1'b1;
        psus <= 1'b1;
        ab   <= 1'b1;
        repeat (4) @(posedge clk);
        check("status2", s2, 8'h8C);
        check("status1", s1, 8'h01);
        esus <= 1'b0;
        psus <= 1'b0;
        ab   <= 1'b0;
        repeat (4) @(posedge clk);
        $display("test lock done");
    endtask
    task t_reset;
        check("ready", {s1[0], s2[7], s2[2]}, 0);
        host.frame('{8'h66}, 8, 0);
        host.frame('{8'h06}, 8, 0);
        host.frame('{8'h99}, 8, 0);
        check("resets", resets, 0);
        check("wel", write_enable_latch, 1);
        host.frame('{8'h66}, 8, 0);
        host.frame('{8'h99}, 8, 0);
        check("resets", resets, 1);
        check("wel", write_enable_latch, 0);
        check("busy", busy, 1);
        we();
        check("wel", write_enable_latch, 0);
        wait_idle();
        we();
        check("wel", write_enable_latch, 1);
        $display("test reset done");
    endtask
    initial begin
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_we();
        t_erase_prog();
        t_abort();
        t_lock();
        t_reset();
        finish_test();
    end
endmodule
